// ===== hdl/epms_map.svh
/*
 * Register offsets, field positions and reset values of the external
 * program memory and strap port.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef EPMS_MAP_SVH
`define EPMS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EPMS_OFS_CTRL 8'h00
`define EPMS_OFS_STATUS 8'h04

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define EPMS_CTRL_IDLE 0
`define EPMS_CTRL_SLEEP 1
`define EPMS_CTRL_ROM_SEL 2
`define EPMS_CTRL_RESET 3'h0

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define EPMS_ST_IR_POL 0
`define EPMS_ST_CLK_DRIVE 1
`define EPMS_ST_FREQ_LO 2
`define EPMS_ST_FREQ_HI 3
`define EPMS_ST_FREQ_RSVD 4
`define EPMS_ST_PARKED 5
`define EPMS_ST_IN_RESET 6

// ----------------------------------------------------------------------
// Strap codes and reset values
// ----------------------------------------------------------------------
`define EPMS_CLK_CRYSTAL 1'h0
`define EPMS_CLK_EXTERNAL 1'h1
`define EPMS_FREQ_24MHZ 2'h0
`define EPMS_FREQ_48MHZ 2'h3
`define EPMS_STRAP_RESET 4'h0
`define EPMS_STRAP_PINS 4

`endif

// ===== hdl/epms_pkg.sv
/*
 * Types of the external program memory and strap port.
 * Assumes epms_map.svh holds all numeric constants.
 */
package epms_pkg;

    typedef struct packed {
        logic rom_sel;
        logic sleep;
        logic idle;
    } epms_ctrl_t;

    typedef struct packed {
        logic ir_pol;
        logic clk_drive;
        logic [1:0] freq;
    } epms_strap_t;

    typedef enum logic [1:0] {
        EPMS_HELD = 2'h0,
        EPMS_RUN = 2'h1
    } epms_state_t;

endpackage : epms_pkg

// ===== hdl/epms_port.sv
/*
 * External program memory address/data pins with reset-time straps.
 * Assumes an Avalon-MM master on sys_clk, a CPU memory port on sys_clk,
 * and board pads that resolve pulls and enables into pin levels.
 */
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
// Function
// - Clock comes from 24 MHz crystal or external 24/48 MHz source.
// - Sample address pins 3..0 during reset, latch them at negation.
// - With internal ROM select 0, data bus moves external memory data.
// - Drive address bits 15..3 to address external program memory.
// - Address bit 3 is LED polarity strap; pull-up on during reset.
// - At negation latch polarity, drop pull-up, drive address bit 3.
// - Address bit 2 is clock mode strap; pull-down on during reset.
// - Clock mode 0 is crystal 24 MHz, 1 is external 24/48 MHz.
// - At negation latch clock mode, drop pull-down, drive bit 2.
// - External mode: float bit 2 when idle, no interrupt two, sleep.
// - Crystal mode: bit 2 drives like other address bits after reset.
// - Frequency strap 00 is 24 MHz, 11 is 48 MHz, others reserved.
`timescale 1ns/1ns
`include "epms_map.svh"

module epms_port #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Chip pins from outside
    input wire logic chip_reset_low,
    input wire logic external_interrupt_two,
    // CPU memory port
    input wire logic [ADDR_W-1:0] cpu_mem_addr,
    input wire logic [DATA_W-1:0] cpu_mem_wdata,
    input wire logic cpu_mem_write,
    output logic [DATA_W-1:0] cpu_mem_rdata,
    // Infrared transmit
    input wire logic ir_tx_level,
    output logic ir_led_out,
    // Oscillator
    output logic osc_output_drive_en,
    // External memory address pins
    output logic [ADDR_W-1:0] ext_mem_addr_out,
    output logic [ADDR_W-1:0] ext_mem_addr_oe,
    input wire logic [`EPMS_STRAP_PINS-1:0] ext_mem_addr_in,
    output logic ext_mem_addr_bit_three_pullup_en,
    output logic [2:0] ext_mem_addr_low_pulldown_en,
    // External memory data pins
    output logic [DATA_W-1:0] ext_mem_data_bus_out,
    output logic [DATA_W-1:0] ext_mem_data_bus_oe,
    input wire logic [DATA_W-1:0] ext_mem_data_bus_in,
    output logic ext_mem_data_pullup_en
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [`EPMS_STRAP_PINS+1:0] sync_a;
    logic [`EPMS_STRAP_PINS+1:0] sync_b;
    logic [DATA_W-1:0] data_sync_a;
    logic [DATA_W-1:0] data_sync_b;
    logic in_reset;
    logic int_two;
    logic [`EPMS_STRAP_PINS-1:0] strap_pins;

    always_ff @(posedge sys_clk)
    begin
        if (clk_en)
        begin
            // Reset pin inverted so a held chip reads 1
            sync_a <= {~chip_reset_low, external_interrupt_two,
                       ext_mem_addr_in};
            sync_b <= sync_a;
            data_sync_a <= ext_mem_data_bus_in;
            data_sync_b <= data_sync_a;
        end
    end

    assign in_reset = sync_b[`EPMS_STRAP_PINS+1];
    assign int_two = sync_b[`EPMS_STRAP_PINS];
    assign strap_pins = sync_b[`EPMS_STRAP_PINS-1:0];

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    epms_pkg::epms_state_t state;
    epms_pkg::epms_state_t next_state;
    epms_pkg::epms_strap_t strap;
    epms_pkg::epms_strap_t next_strap;

    always_comb
    begin
        next_state = state;
        next_strap = strap;
        case (state)
            epms_pkg::EPMS_HELD:
            begin
                // Follow pins while held, last sample stays at release
                // Pin 3 polarity, pin 2 clock mode, pins 1..0 frequency
                next_strap = epms_pkg::epms_strap_t'(strap_pins);
                if (!in_reset)
                    next_state = epms_pkg::EPMS_RUN;
            end
            epms_pkg::EPMS_RUN:
            begin
                if (in_reset)
                    next_state = epms_pkg::EPMS_HELD;
            end
            default:
                next_state = epms_pkg::EPMS_HELD;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= epms_pkg::EPMS_HELD;
            strap <= epms_pkg::epms_strap_t'(`EPMS_STRAP_RESET);
        end
        else if (clk_en)
        begin
            state <= next_state;
            strap <= next_strap;
        end
    end

    // ------------------------------------------------------------------
    // Control register and Avalon slave
    // ------------------------------------------------------------------
    epms_pkg::epms_ctrl_t ctrl;
    epms_pkg::epms_ctrl_t next_ctrl;
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic held;
    logic parked;
    logic freq_rsvd;
    logic bus_done;

    assign held = (state == epms_pkg::EPMS_HELD);
    // Power-down float condition for pins 2..0 whose latched strap is 1
    assign parked = ctrl.idle && !int_two && ctrl.sleep;
    // Codes 01 and 10 are reserved
    assign freq_rsvd = (strap.freq != `EPMS_FREQ_24MHZ) &&
                       (strap.freq != `EPMS_FREQ_48MHZ);
    // Answer only on an enabled edge, so a frozen clock stretches the wait
    assign bus_done = ack && clk_en;
    assign avs_waitrequest = (avs_read || avs_write) && !bus_done;

    always_comb
    begin
        next_ctrl = ctrl;
        next_ack = (avs_read || avs_write) && !ack;
        next_readdata = avs_readdata;
        // Write lands on the edge where the master sees the answer
        if (bus_done && avs_write)
        begin
            if (avs_address == `EPMS_OFS_CTRL)
            begin
                next_ctrl.idle = avs_writedata[`EPMS_CTRL_IDLE];
                next_ctrl.sleep = avs_writedata[`EPMS_CTRL_SLEEP];
                next_ctrl.rom_sel = avs_writedata[`EPMS_CTRL_ROM_SEL];
            end
        end
        // Read data loads one edge ahead of the answer
        if (next_ack && avs_read)
        begin
            next_readdata = 32'h0;
            if (avs_address == `EPMS_OFS_CTRL)
            begin
                next_readdata[`EPMS_CTRL_IDLE] = ctrl.idle;
                next_readdata[`EPMS_CTRL_SLEEP] = ctrl.sleep;
                next_readdata[`EPMS_CTRL_ROM_SEL] = ctrl.rom_sel;
            end
            else if (avs_address == `EPMS_OFS_STATUS)
            begin
                next_readdata[`EPMS_ST_IR_POL] = strap.ir_pol;
                next_readdata[`EPMS_ST_CLK_DRIVE] = strap.clk_drive;
                next_readdata[`EPMS_ST_FREQ_LO] = strap.freq[0];
                next_readdata[`EPMS_ST_FREQ_HI] = strap.freq[1];
                next_readdata[`EPMS_ST_FREQ_RSVD] = freq_rsvd;
                next_readdata[`EPMS_ST_PARKED] = parked;
                next_readdata[`EPMS_ST_IN_RESET] = held;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl <= epms_pkg::epms_ctrl_t'(`EPMS_CTRL_RESET);
            ack <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else if (clk_en)
        begin
            ctrl <= next_ctrl;
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] next_addr_out;
    logic [ADDR_W-1:0] next_addr_oe;
    logic [DATA_W-1:0] next_data_out;
    logic [DATA_W-1:0] next_data_oe;
    logic [DATA_W-1:0] next_rdata;
    logic next_pullup;
    logic [2:0] next_pulldown;
    logic next_led;
    logic next_osc;
    logic ext_mem;

    assign ext_mem = !ctrl.rom_sel;

    always_comb
    begin
        next_addr_out = cpu_mem_addr;
        next_addr_oe = {ADDR_W{1'b1}};
        next_pullup = 1'b0;
        next_pulldown = 3'h0;
        if (held)
        begin
            // Strap pins listen with pulls on
            next_addr_oe[`EPMS_STRAP_PINS-1:0] = '0;
            next_pullup = 1'b1;
            next_pulldown = 3'h7;
        end
        else if (parked)
        begin
            if (strap.clk_drive == `EPMS_CLK_EXTERNAL)
                next_addr_oe[2] = 1'b0;
            // Frequency pins strapped to 1 float as well
            next_addr_oe[1:0] = ~strap.freq;
        end
        next_data_out = cpu_mem_wdata;
        next_data_oe = '0;
        next_rdata = cpu_mem_rdata;
        if (ext_mem && !held)
        begin
            if (cpu_mem_write)
                next_data_oe = {DATA_W{1'b1}};
            else
                next_rdata = data_sync_b;
        end
        // Polarity 1 drives the LED high when transmitting
        next_led = strap.ir_pol ? ir_tx_level : !ir_tx_level;
        // Crystal driver runs only in crystal mode
        next_osc = (strap.clk_drive == `EPMS_CLK_CRYSTAL);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ext_mem_addr_out <= '0;
            ext_mem_addr_oe <= '0;
            ext_mem_bit_pulls_reset();
            ext_mem_data_bus_out <= '0;
            ext_mem_data_bus_oe <= '0;
            cpu_mem_rdata <= '0;
            ir_led_out <= 1'b0;
            osc_output_drive_en <= 1'b1;
        end
        else if (clk_en)
        begin
            ext_mem_addr_out <= next_addr_out;
            ext_mem_addr_oe <= next_addr_oe;
            ext_mem_addr_bit_three_pullup_en <= next_pullup;
            ext_mem_addr_low_pulldown_en <= next_pulldown;
            ext_mem_data_bus_out <= next_data_out;
            ext_mem_data_bus_oe <= next_data_oe;
            cpu_mem_rdata <= next_rdata;
            ir_led_out <= next_led;
            osc_output_drive_en <= next_osc;
        end
    end

    // Pulls stay on through reset so straps read cleanly
    task automatic ext_mem_bit_pulls_reset();
        ext_mem_addr_bit_three_pullup_en <= 1'b1;
        ext_mem_addr_low_pulldown_en <= 3'h7;
    endtask : ext_mem_bit_pulls_reset

    // Data pads keep their pull-ups unless driven
    assign ext_mem_data_pullup_en = ~|ext_mem_data_bus_oe;

endmodule : epms_port

// ===== sim/epms_port_properties.sv
/* Checker of the strap port, bound to every epms_port instance.
   Assumes clk_en stays high while straps and pins are exercised. */
`timescale 1ns/1ns
`include "epms_map.svh"
module epms_port_properties (
    // Clock and bus
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Pins and CPU side
    input wire logic chip_reset_low,
    input wire logic external_interrupt_two,
    input wire logic [15:0] cpu_mem_addr,
    input wire logic [7:0] cpu_mem_wdata,
    input wire logic cpu_mem_write,
    input wire logic ir_tx_level,
    input wire logic ir_led_out,
    input wire logic osc_output_drive_en,
    input wire logic [15:0] ext_mem_addr_out,
    input wire logic [15:0] ext_mem_addr_oe,
    input wire logic ext_mem_addr_bit_three_pullup_en,
    input wire logic [2:0] ext_mem_addr_low_pulldown_en,
    input wire logic [7:0] ext_mem_data_bus_out,
    input wire logic [7:0] ext_mem_data_bus_oe
);
    epms_pkg::epms_ctrl_t ctl;
    epms_pkg::epms_ctrl_t next_ctl;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Shadow of the control register
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctl = ctl;
        if (avs_write && !avs_waitrequest && avs_address == `EPMS_OFS_CTRL)
            next_ctl = epms_pkg::epms_ctrl_t'(avs_writedata[2:0]);
        if (rst)
            next_ctl = epms_pkg::epms_ctrl_t'(`EPMS_CTRL_RESET);
    end
    always_ff @(posedge sys_clk)
        ctl <= next_ctl;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_addr_follow: assert property (
        $past(clk_en) && !$past(rst) |-> ext_mem_addr_out == $past(cpu_mem_addr))
        else $error("address outputs lag wrong");
    a_held_pulls: assert property (
        (!chip_reset_low)[*5] |-> ext_mem_addr_bit_three_pullup_en
        && &ext_mem_addr_low_pulldown_en && ext_mem_addr_oe[3:0] == 4'h0)
        else $error("pulls off or strap pins driven in chip reset");
    a_run_pulls: assert property (
        chip_reset_low[*6] |-> !ext_mem_addr_bit_three_pullup_en
        && ext_mem_addr_low_pulldown_en == 3'h0 && &ext_mem_addr_oe[15:3])
        else $error("pulls on or address undriven after chip reset");
    a_wake_drive: assert property (
        (chip_reset_low && external_interrupt_two)[*6] |-> ext_mem_addr_oe[2])
        else $error("address bit two floats while interrupt two high");
    a_park_float: assert property (
        (chip_reset_low && !external_interrupt_two && ctl.idle
        && ctl.sleep)[*6] |-> ext_mem_addr_oe[2] == osc_output_drive_en)
        else $error("address bit two park wrong for clock mode");
    a_led_hold: assert property (
        chip_reset_low[*8] |-> (ir_led_out ^ $past(ir_tx_level))
        == ($past(ir_led_out) ^ $past(ir_tx_level, 2)))
        else $error("led polarity changed while running");
    a_osc_hold: assert property (
        chip_reset_low[*8] |-> $stable(osc_output_drive_en))
        else $error("clock mode changed while running");
    a_data_drive: assert property (
        chip_reset_low[*6] ##0 (cpu_mem_write && !ctl.rom_sel) |=>
        ext_mem_data_bus_oe == 8'hFF
        && ext_mem_data_bus_out == $past(cpu_mem_wdata))
        else $error("data bus not driven on cpu write");
    a_data_refuse: assert property (
        $past(ctl.rom_sel) |-> ext_mem_data_bus_oe == 8'h00)
        else $error("data bus driven with internal rom");
endmodule : epms_port_properties

bind epms_port epms_port_properties u_epms_port_properties (.sys_clk, .rst,
    .clk_en, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .chip_reset_low, .external_interrupt_two, .cpu_mem_addr, .cpu_mem_wdata,
    .cpu_mem_write, .ir_tx_level, .ir_led_out, .osc_output_drive_en,
    .ext_mem_addr_out, .ext_mem_addr_oe, .ext_mem_addr_bit_three_pullup_en,
    .ext_mem_addr_low_pulldown_en, .ext_mem_data_bus_out, .ext_mem_data_bus_oe);

// ===== sim/epms_board.sv
/* Far side of the strap port: board strap resistors and program memory.
   Assumes straps outvote the weak pulls and memory drives when released. */
`timescale 1ns/1ns
module epms_board (
    // Clock and board straps
    input wire logic sys_clk,
    input wire logic [3:0] strap,
    // Address pins
    input wire logic [15:0] ext_mem_addr_out,
    input wire logic [15:0] ext_mem_addr_oe,
    output logic [3:0] ext_mem_addr_in,
    // Data pins
    input wire logic [7:0] ext_mem_data_bus_out,
    input wire logic [7:0] ext_mem_data_bus_oe,
    output logic [7:0] ext_mem_data_bus_in
);
    logic [7:0] mem [0:255];
    initial
        foreach (mem[i])
            mem[i] = ~i[7:0];
    always_comb
        for (int i = 0; i < 4; i++)
            ext_mem_addr_in[i] = ext_mem_addr_oe[i] ?
                ext_mem_addr_out[i] : strap[i];
    always @(posedge sys_clk)
        if (&ext_mem_data_bus_oe)
            mem[ext_mem_addr_out[7:0]] <= ext_mem_data_bus_out;
    always_comb
        for (int i = 0; i < 8; i++)
            ext_mem_data_bus_in[i] = ext_mem_data_bus_oe[i] ?
                ext_mem_data_bus_out[i] : mem[ext_mem_addr_out[7:0]][i];
endmodule : epms_board

// ===== sim/tb_epms_port.sv
/* Self-checking bench of the strap port.
   Assumes epms_board on the far side and the bound checker. */
`timescale 1ns/1ns
`include "epms_map.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_epms_port;
    logic sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1;
    logic avs_read = 1'h0, avs_write = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, exp_v;
    logic avs_waitrequest, ir_led_out, osc_output_drive_en;
    logic chip_reset_low = 1'h1, external_interrupt_two = 1'h0;
    logic [15:0] cpu_mem_addr = 16'h0, ext_mem_addr_out, ext_mem_addr_oe;
    logic [7:0] cpu_mem_wdata = 8'h00, cpu_mem_rdata;
    logic cpu_mem_write = 1'h0, ir_tx_level = 1'h0;
    logic [3:0] ext_mem_addr_in, strap = 4'h0;
    logic ext_mem_addr_bit_three_pullup_en, ext_mem_data_pullup_en;
    logic [2:0] ext_mem_addr_low_pulldown_en;
    logic [7:0] ext_mem_data_bus_out, ext_mem_data_bus_oe, ext_mem_data_bus_in;
    logic [31:0] exp_q [$];
    int error_cnt = 0, n_checks = 0;
    epms_port u_epms_port (.sys_clk, .rst, .clk_en, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .chip_reset_low, .external_interrupt_two, .cpu_mem_addr, .cpu_mem_wdata,
        .cpu_mem_write, .cpu_mem_rdata, .ir_tx_level, .ir_led_out,
        .osc_output_drive_en, .ext_mem_addr_out, .ext_mem_addr_oe,
        .ext_mem_addr_in, .ext_mem_addr_bit_three_pullup_en,
        .ext_mem_addr_low_pulldown_en, .ext_mem_data_bus_out,
        .ext_mem_data_bus_oe, .ext_mem_data_bus_in, .ext_mem_data_pullup_en);
    epms_board u_epms_board (.sys_clk, .strap, .ext_mem_addr_out,
        .ext_mem_addr_oe, .ext_mem_addr_in, .ext_mem_data_bus_out,
        .ext_mem_data_bus_oe, .ext_mem_data_bus_in);
    initial
        forever #20 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // Bus master and read monitor
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask : rd
    always @(posedge sys_clk)
        if (avs_read && avs_waitrequest === 1'h0)
        begin
            exp_v = exp_q.pop_front();
            `CHK("readdata", exp_v, avs_readdata)
        end
    // ------------------------------------------------------------
    // One pass through chip reset with a given strap
    // ------------------------------------------------------------
    task automatic run_strap(input logic [3:0] s);
        logic [7:0] d;
        logic [15:0] a;
        logic [31:0] st;
        d = 8'($urandom);
        a = 16'($urandom);
        st = {27'h0, s[1] ^ s[0], s[1:0], s[2], s[3]};
        @(posedge sys_clk);
        strap <= s;
        chip_reset_low <= 1'h0;
        repeat (6) @(posedge sys_clk);
        `CHK("pullup", 1'h1, ext_mem_addr_bit_three_pullup_en)
        `CHK("pulldown", 3'h7, ext_mem_addr_low_pulldown_en)
        chip_reset_low <= 1'h1;
        repeat (6) @(posedge sys_clk);
        `CHK("osc", ~s[2], osc_output_drive_en)
        ir_tx_level <= d[0];
        cpu_mem_addr <= a;
        cpu_mem_wdata <= d;
        cpu_mem_write <= 1'h1;
        repeat (2) @(posedge sys_clk);
        `CHK("led", d[0] ~^ s[3], ir_led_out)
        `CHK("addr", a, ext_mem_addr_out)
        `CHK("addr_oe", 13'h1FFF, ext_mem_addr_oe[15:3])
        `CHK("data", d, ext_mem_data_bus_out)
        `CHK("data_oe", 8'hFF, ext_mem_data_bus_oe)
        `CHK("data_pull", 1'h0, ext_mem_data_pullup_en)
        cpu_mem_write <= 1'h0;
        repeat (6) @(posedge sys_clk);
        `CHK("rdata", d, cpu_mem_rdata)
        rd(`EPMS_OFS_STATUS, st);
        bus(1'h1, `EPMS_OFS_CTRL, 32'h3);
        repeat (5) @(posedge sys_clk);
        `CHK("park_oe", ~s[2], ext_mem_addr_oe[2])
        `CHK("park_low", ~s[1:0], ext_mem_addr_oe[1:0])
        rd(`EPMS_OFS_STATUS, st | 32'h20);
        external_interrupt_two <= 1'h1;
        repeat (5) @(posedge sys_clk);
        `CHK("wake_oe", 1'h1, ext_mem_addr_oe[2])
        external_interrupt_two <= 1'h0;
        bus(1'h1, `EPMS_OFS_CTRL, 32'h4);
        cpu_mem_write <= 1'h1;
        repeat (2) @(posedge sys_clk);
        `CHK("rom_oe", 8'h00, ext_mem_data_bus_oe)
        `CHK("rom_pull", 1'h1, ext_mem_data_pullup_en)
        cpu_mem_write <= 1'h0;
        bus(1'h1, `EPMS_OFS_CTRL, 32'h0);
    endtask : run_strap
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h2494D1E5));
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        rd(8'h08, 32'h0);
        bus(1'h1, `EPMS_OFS_STATUS, 32'hFF);
        // Clock enable drops while a write waits for its answer
        fork
            bus(1'h1, `EPMS_OFS_CTRL, 32'h7);
            begin
                repeat (2) @(posedge sys_clk);
                clk_en <= 1'h0;
                repeat (2) @(posedge sys_clk);
                clk_en <= 1'h1;
            end
        join
        rd(`EPMS_OFS_CTRL, 32'h7);
        bus(1'h1, `EPMS_OFS_CTRL, 32'h0);
        for (int s = 0; s < 16; s++)
            run_strap(4'(s));
        end_of_test();
    end
endmodule : tb_epms_port
